// ==== design/dmb_pkg.sv ====
// package for the data memory bank addressing block
package dmb_pkg;
  localparam logic [7:0] ADDR_IND_BANK_ZERO = 8'h00;
  localparam logic [7:0] ADDR_PTR_BANK_ZERO = 8'h01;
  localparam logic [7:0] ADDR_IND_ANY_BANK = 8'h02;
  localparam logic [7:0] ADDR_PTR_ANY_BANK = 8'h03;
  localparam logic [7:0] ADDR_BANK_POINTER = 8'h04;
  localparam logic [7:0] ADDR_GP_START = 8'h40;
  localparam logic [7:0] ADDR_LCD_LAST = 8'h5f;
  localparam logic [7:0] BANK_POINTER_RST = 8'h00;
  localparam logic [7:0] BANK_POINTER_IMPL = 8'hff;
  localparam int PROG_BANK_BIT = 5;
  localparam logic [2:0] BANK_GP0 = 3'h0;
  localparam logic [2:0] BANK_LCD = 3'h1;
  localparam logic [2:0] BANK_NONE = 3'h7;
  localparam int GP_WORDS = 192;
  localparam int LCD_WORDS = 32;
  localparam int GP_BANKS = 7;

  // one memory request from the core datapath
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dmb_req_s;

  // the resolved target of one access
  typedef struct packed {
    logic sfr_hit;
    logic mem_hit;
    logic [2:0] bank;
    logic [7:0] addr;
  } dmb_tgt_s;
endpackage

// ==== design/dmb_bank_addr.sv ====
// data memory address generation with indirect ports and bank pointer
`timescale 1ns/1ps
// Overview of operation
// - sfr space at zero, unused reads zero
// - indirect port acts at pointer address
// - port zero bank 0, port one selected bank
// - indirect to indirect port: zero, no write
// - both pointers are real read/write registers
// - three bit field picks bank, 111 unimplemented
// - reset selects bank 0 except watchdog sleep
// - sfr addresses identical in every bank
// - direct accesses always land in bank 0
// - bit 5 selects program memory bank
// - bank 1 below 40h gives bank 0 sfr
// - bank 1 beyond display memory reads zero
module dmb_bank_addr
  import dmb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wdt_sleep_reset,
  input wire dmb_req_s req,
  input wire logic [7:0] sfr_rdata,
  output logic sfr_rd,
  output logic sfr_wr,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic [7:0] rdata,
  output logic program_bank_select,
  output logic [2:0] data_bank_select
);
  // ==========================================================
  // storage
  logic [7:0] bank_pointer_r;
  logic [7:0] pointer_bank_zero_r;
  logic [7:0] pointer_any_bank_r;
  logic [7:0] lcd_mem_r [LCD_WORDS];
  logic [7:0] rdata_r;
  dmb_tgt_s tgt;
  logic ind_sel;
  logic [7:0] eff_addr;
  logic [2:0] eff_bank;
  logic local_reg;
  logic [7:0] mem_rd;
  logic ptr_zero_hit;
  logic ptr_any_hit;
  logic bank_ptr_hit;
  logic port_loop;
  logic lcd_hit;
  logic gp_hit;
  logic [7:0] mem_idx;
  logic [7:0] rd_sel;
  logic [7:0] bank_rd [GP_BANKS];

  assign data_bank_select = bank_pointer_r[2:0];
  assign program_bank_select = bank_pointer_r[PROG_BANK_BIT];
  assign rdata = rdata_r;

  // ==========================================================
  // address resolution
  // an indirect access whose pointer names a port again is dropped, so no chain forms
  always_comb
  begin
    ind_sel = 1'b0;
    eff_addr = req.addr;
    eff_bank = BANK_GP0;
    if (req.addr == ADDR_IND_BANK_ZERO)
    begin
      ind_sel = 1'b1;
      eff_addr = pointer_bank_zero_r;
      eff_bank = BANK_GP0;
    end
    else if (req.addr == ADDR_IND_ANY_BANK)
    begin
      ind_sel = 1'b1;
      eff_addr = pointer_any_bank_r;
      eff_bank = bank_pointer_r[2:0];
    end
    tgt.addr = eff_addr;
    tgt.bank = eff_bank;
    tgt.sfr_hit = 1'b0;
    tgt.mem_hit = 1'b0;
    if (ind_sel && (eff_addr == ADDR_IND_BANK_ZERO || eff_addr == ADDR_IND_ANY_BANK))
    begin
      tgt.sfr_hit = 1'b0;
    end
    else if (eff_addr < ADDR_GP_START)
    begin
      tgt.sfr_hit = 1'b1;
    end
    else if (eff_bank == BANK_NONE)
    begin
      tgt.mem_hit = 1'b0;
    end
    else if (eff_bank == BANK_LCD)
    begin
      tgt.mem_hit = (eff_addr <= ADDR_LCD_LAST);
    end
    else
    begin
      tgt.mem_hit = 1'b1;
    end
  end

  // pointer and bank registers are answered here, other sfrs go out
  assign local_reg = tgt.sfr_hit && (tgt.addr == ADDR_PTR_BANK_ZERO ||
    tgt.addr == ADDR_PTR_ANY_BANK || tgt.addr == ADDR_BANK_POINTER);
  assign sfr_rd = req.rd && tgt.sfr_hit && !local_reg;
  assign sfr_wr = req.wr && tgt.sfr_hit && !local_reg;
  assign sfr_addr = tgt.addr;
  assign sfr_wdata = req.wdata;

  // ==========================================================
  // address map as seen from the core
  //   00h     port into bank 0 at the address in pointer_bank_zero
  //   01h     pointer_bank_zero, answered locally
  //   02h     port into the selected bank at pointer_any_bank
  //   03h     pointer_any_bank, answered locally
  //   04h     bank_pointer, answered locally
  //   05h-3fh other special registers, passed out on the sfr strobes
  //   40h-ffh general purpose memory, bank 0 when addressed directly
  // the special range is decoded before the bank, so it looks the same
  // from every bank and a bad bank code can never hide the core's registers
  //
  // bank codes in data_bank_select
  //   0       general purpose bank 0
  //   1       display memory, 40h-5fh only, higher offsets read zero
  //   2 to 6  general purpose banks 2 to 6
  //   7       nothing: reads give zero and writes are dropped
  //
  // timing
  //   a request is taken on the rising edge where rd or wr is high
  //   writes land on that edge, read data shows one cycle later
  //   back to back requests are fine, one per cycle
  //   the sfr strobes are combinational and the outside register answers
  //   in the same cycle; this keeps a one cycle read at the cost of a long path

  // ==========================================================
  // local decode
  // one hit line per local register, shared by reads and writes so that the
  // two can never disagree about which register an access means
  assign ptr_zero_hit = local_reg && (tgt.addr == ADDR_PTR_BANK_ZERO);
  assign ptr_any_hit = local_reg && (tgt.addr == ADDR_PTR_ANY_BANK);
  assign bank_ptr_hit = local_reg && (tgt.addr == ADDR_BANK_POINTER);

  // an indirect access that lands on a port again; named on its own so that
  // the read mux returns zero for it whatever the target logic does; no write path uses it
  assign port_loop = ind_sel &&
    (tgt.addr == ADDR_IND_BANK_ZERO || tgt.addr == ADDR_IND_ANY_BANK);

  // memory targets split by kind; bank 1 holds display memory only
  assign lcd_hit = tgt.mem_hit && (tgt.bank == BANK_LCD);
  assign gp_hit = tgt.mem_hit && (tgt.bank != BANK_LCD);

  // offset into a bank; only meaningful when one of the hits above is set
  assign mem_idx = tgt.addr - ADDR_GP_START;

  // ==========================================================
  // read mux
  always_comb
  begin
    mem_rd = 8'h00;
    if (lcd_hit)
    begin
      mem_rd = lcd_mem_r[mem_idx[4:0]];
    end
    else if (gp_hit)
    begin
      mem_rd = bank_rd[tgt.bank];
    end
  end

  // read source select; whatever no branch claims reads back as zero
  always_comb
  begin
    rd_sel = 8'h00;
    if (ptr_zero_hit)
      rd_sel = pointer_bank_zero_r;
    else if (ptr_any_hit)
      rd_sel = pointer_any_bank_r;
    else if (bank_ptr_hit)
      rd_sel = bank_pointer_r;
    else if (port_loop)
      rd_sel = 8'h00;
    else if (tgt.sfr_hit)
      rd_sel = sfr_rdata;
    else
      rd_sel = mem_rd;
  end

  // read data is registered so it stands until the next read
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdata_r <= 8'h00;
    else if (req.rd)
      rdata_r <= rd_sel;
  end

  // ==========================================================
  // pointer registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pointer_bank_zero_r <= 8'h00;
      pointer_any_bank_r <= 8'h00;
    end
    else if (req.wr)
    begin
      if (ptr_zero_hit)
        pointer_bank_zero_r <= req.wdata;
      else if (ptr_any_hit)
        pointer_any_bank_r <= req.wdata;
    end
  end

  // bank pointer: a watchdog wake from sleep must keep the selection, so
  // the core holds rst low then and pulses wdt_sleep_reset instead
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      bank_pointer_r <= BANK_POINTER_RST;
    else if (wdt_sleep_reset)
      bank_pointer_r <= bank_pointer_r;
    else if (req.wr && bank_ptr_hit)
      bank_pointer_r <= req.wdata & BANK_POINTER_IMPL;
  end

  // ==========================================================
  // general purpose banks, one generate entry per bank
  // each bank owns its storage, so no array is written from two processes
  genvar gb;
  generate
    for (gb = 0; gb < GP_BANKS; gb++)
    begin : g_bank
      if (gb != 1)
      begin : g_gp
        logic [7:0] mem_r [GP_WORDS];
        logic wr_here;
        // a bank takes a write only while it is the resolved target
        assign wr_here = req.wr && gp_hit && (tgt.bank == 3'(gb));
        always_ff @(posedge clk_sys)
        begin
          if (wr_here)
            mem_r[mem_idx] <= req.wdata;
        end
        // read port; the mux only looks here when gp_hit names this bank
        assign bank_rd[gb] = mem_r[mem_idx];
      end
      else
      begin : g_lcd_slot
        // bank 1 is display memory, kept apart below; this slot reads zero
        assign bank_rd[gb] = 8'h00;
      end
    end
  endgenerate

  // ==========================================================
  // display memory
  // it lives only in bank 1 and is small, offsets past it never get a hit
  always_ff @(posedge clk_sys)
  begin
    if (req.wr && lcd_hit)
      lcd_mem_r[mem_idx[4:0]] <= req.wdata;
  end
endmodule

// ==== sim/dmb_sfr_model.sv ====
// model of the special function registers outside the block
`timescale 1ns/1ps
module dmb_sfr_model
  import dmb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata
);
  // =====
  // plain storage, locations never written read zero
  logic [7:0] regs_r [64];
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      regs_r <= '{default: 8'h00};
    else if (sfr_wr)
      regs_r[sfr_addr[5:0]] <= sfr_wdata;
  end
  // unselected bus shows the inverted address so a stale value never passes
  assign sfr_rdata = sfr_rd ? regs_r[sfr_addr[5:0]] : ~sfr_addr;
endmodule

// ==== sim/dmb_bank_addr_properties.sv ====
// checker for the data memory bank addressing ports
`timescale 1ns/1ps
module dmb_bank_addr_chk
  import dmb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wdt_sleep_reset,
  input wire dmb_req_s req,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] rdata,
  input wire logic program_bank_select,
  input wire logic [2:0] data_bank_select
);
  // =====
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // bank pointer write and plain sfr window
  logic bpw;
  logic sfrx;
  logic [3:0] bank_sel_all;
  assign bank_sel_all = {program_bank_select, data_bank_select};
  assign bpw = req.wr && req.addr == ADDR_BANK_POINTER && !wdt_sleep_reset;
  assign sfrx = req.addr > ADDR_BANK_POINTER && req.addr < ADDR_GP_START;
  chk_bank_load: assert property (bpw |=> data_bank_select == $past(req.wdata[2:0]))
    else $error("bank field not loaded");
  chk_prog_bank: assert property (bpw |=> program_bank_select == $past(req.wdata[5]))
    else $error("program bank not loaded");
  chk_bank_kept: assert property (!bpw |=> $stable(data_bank_select))
    else $error("bank changed without write");
  chk_wdt_keep: assert property (wdt_sleep_reset |=> $stable(bank_sel_all))
    else $error("bank changed on watchdog wake");
  chk_sfr_read: assert property (req.rd && sfrx |-> sfr_rd && sfr_addr == req.addr)
    else $error("sfr read not passed out");
  chk_sfr_data: assert property (req.rd && sfrx |=> rdata == $past(sfr_rdata))
    else $error("sfr data not returned");
  chk_sfr_write: assert property (req.wr && sfrx |-> sfr_wr && sfr_wdata == req.wdata)
    else $error("sfr write not passed out");
  chk_local_regs: assert property (req.addr inside {8'h01, 8'h03, 8'h04} |-> !sfr_rd && !sfr_wr)
    else $error("local register leaked out");
  chk_direct_gp: assert property (req.rd && req.addr >= ADDR_GP_START |-> !sfr_rd)
    else $error("direct memory read went out");
endmodule
bind dmb_bank_addr dmb_bank_addr_chk u_dmb_bank_addr_chk (.clk_sys, .rst, .wdt_sleep_reset, .req, .sfr_rdata,
  .sfr_rd, .sfr_wr, .sfr_addr, .sfr_wdata, .rdata, .program_bank_select, .data_bank_select);

// ==== sim/dmb_bank_addr_bench.sv ====
// self-checking bench for data memory bank addressing
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module dmb_bank_addr_bench
  import dmb_pkg::*;
;
  // =====
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wdt_sleep_reset = 1'b0;
  dmb_req_s req = '0;
  logic sfr_rd, sfr_wr, program_bank_select;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rdata;
  logic [2:0] data_bank_select;
  int err_total = 0;
  int cmp_count = 0;
  dmb_bank_addr u_dmb_bank_addr (.clk_sys, .rst, .wdt_sleep_reset, .req, .sfr_rdata, .sfr_rd,
    .sfr_wr, .sfr_addr, .sfr_wdata, .rdata, .program_bank_select, .data_bank_select);
  dmb_sfr_model u_dmb_sfr_model (.clk_sys, .rst, .sfr_rd, .sfr_wr, .sfr_addr, .sfr_wdata,
    .sfr_rdata);
  initial forever #25 clk_sys = ~clk_sys;
  // one request per call, an idle edge between calls
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_sys);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    req <= '0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // main sequence; banks hold their own copy of 41h
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_BANK_POINTER, 8'h00);
    wr(ADDR_BANK_POINTER, 8'hff);
    rd(ADDR_BANK_POINTER, 8'hff);
    `CHK({program_bank_select, data_bank_select}, 4'hf)
    wr(ADDR_PTR_ANY_BANK, 8'h41);
    wr(ADDR_IND_ANY_BANK, 8'h77);
    rd(ADDR_IND_ANY_BANK, 8'h00);
    $display("test bank_pointer done");
    for (int b = 0; b < 7; b++)
    begin
      wr(ADDR_BANK_POINTER, 8'(b));
      wr(ADDR_IND_ANY_BANK, 8'(b + 16));
    end
    for (int b = 0; b < 7; b++)
    begin
      wr(ADDR_BANK_POINTER, 8'(b));
      rd(ADDR_IND_ANY_BANK, 8'(b + 16));
    end
    wr(ADDR_PTR_BANK_ZERO, 8'h41);
    rd(ADDR_PTR_BANK_ZERO, 8'h41);
    rd(ADDR_IND_BANK_ZERO, 8'h10);
    wr(8'h41, 8'hc3);
    rd(ADDR_IND_BANK_ZERO, 8'hc3);
    wr(ADDR_PTR_BANK_ZERO, ADDR_IND_ANY_BANK);
    wr(ADDR_IND_BANK_ZERO, 8'h99);
    rd(ADDR_IND_BANK_ZERO, 8'h00);
    rd(ADDR_IND_ANY_BANK, 8'h16);
    $display("test indirect done");
    wr(ADDR_BANK_POINTER, 8'h01);
    wr(ADDR_PTR_ANY_BANK, 8'h60);
    rd(ADDR_IND_ANY_BANK, 8'h00);
    wr(8'h20, 8'h5a);
    wr(ADDR_PTR_ANY_BANK, 8'h20);
    rd(ADDR_IND_ANY_BANK, 8'h5a);
    rd(8'h3f, 8'h00);
    // watchdog wake keeps the selection even against a stray write
    wr(ADDR_BANK_POINTER, 8'h23);
    @(posedge clk_sys);
    wdt_sleep_reset <= 1'b1;
    req <= '{rd: 1'b0, wr: 1'b1, addr: ADDR_BANK_POINTER, wdata: 8'h00};
    @(posedge clk_sys);
    wdt_sleep_reset <= 1'b0;
    req <= '0;
    #1;
    `CHK({program_bank_select, data_bank_select}, 4'hb)
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    `CHK({program_bank_select, data_bank_select}, 4'h0)
    rd(ADDR_BANK_POINTER, 8'h00);
    $display("test bank1 and reset done");
    results();
  end
  // hang guard
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    results();
  end
endmodule
